// [src/lsb_pkg.sv]
package lsb_pkg;
	// ---------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_OPA = 12'h004;
	localparam logic [11:0] OFS_OPB = 12'h008;
	localparam logic [11:0] OFS_IMM = 12'h00C;
	localparam logic [11:0] OFS_SW = 12'h010;
	localparam logic [11:0] OFS_PC = 12'h014;
	localparam logic [11:0] OFS_DISP = 12'h018;
	localparam logic [11:0] OFS_RES = 12'h01C;
	localparam logic [11:0] OFS_EVT = 12'h020;
	localparam logic [11:0] OFS_USP = 12'h024;
	localparam logic [11:0] OFS_INFO = 12'h028;
	// ---------------------------------------------
	// Status word fields
	// ---------------------------------------------
	localparam int SW_C = 0;
	localparam int SW_V = 1;
	localparam int SW_Z = 2;
	localparam int SW_N = 3;
	localparam int SW_X = 4;
	localparam int SW_S = 13;
	localparam logic [15:0] SW_RST = 16'h2700;
	localparam logic [15:0] SW_IMPL = 16'hA71F;
	localparam logic [15:0] CCB_MASK = 16'h001F;
	// ---------------------------------------------
	// Events and exceptions
	// ---------------------------------------------
	localparam int EV_DONE = 0;
	localparam int EV_TRAP = 1;
	localparam int EV_PRIV = 2;
	localparam logic [1:0] EXC_TRAP = 2'h0;
	localparam logic [1:0] EXC_TRAPO = 2'h1;
	localparam logic [1:0] EXC_CHK = 2'h2;
	localparam logic [1:0] EXC_PRIV = 2'h3;
	// ---------------------------------------------
	// Timing, operand sizes, opcodes and control word
	// ---------------------------------------------
	localparam int CLK_NS = 5;
	localparam int XRST_NS = 620;
	localparam int XRST_CYC = (XRST_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] SZ_B = 2'h0;
	localparam logic [1:0] SZ_W = 2'h1;
	typedef enum logic [5:0] {
		OP_AND = 6'h00, OP_OR = 6'h01, OP_XOR = 6'h02, OP_NOT = 6'h03,
		OP_ANDK = 6'h04, OP_ORK = 6'h05, OP_XORI = 6'h06,
		OP_ASHL = 6'h07, OP_ASHR = 6'h08, OP_LSHL = 6'h09, OP_LSHR = 6'h0A,
		OP_ROTL = 6'h0B, OP_ROTR = 6'h0C, OP_RXL = 6'h0D, OP_RXR = 6'h0E,
		OP_BITT = 6'h0F, OP_BITS = 6'h10, OP_BITC = 6'h11, OP_BINV = 6'h12,
		OP_DADD = 6'h13, OP_DSUB = 6'h14, OP_DNEG = 6'h15,
		OP_CBR = 6'h16, OP_DBR = 6'h17, OP_CSET = 6'h18,
		OP_RTRF = 6'h19, OP_ERET = 6'h1A, OP_XRST = 6'h1B, OP_STOP = 6'h1C,
		OP_USP = 6'h1D, OP_ANDSW = 6'h1E, OP_ORSW = 6'h1F, OP_XORSW = 6'h20,
		OP_LDSW = 6'h21, OP_ANDCC = 6'h22, OP_ORCC = 6'h23, OP_XORCC = 6'h24,
		OP_LDCC = 6'h25, OP_STSW = 6'h26, OP_TRAP = 6'h27, OP_TRAPO = 6'h28,
		OP_CHK = 6'h29
	} lsb_op_t;
	typedef struct packed {
		logic [3:0] rsv3;
		logic [3:0] vec;
		logic [1:0] rsv2;
		logic d16;
		logic [2:0] cnt;
		logic creg;
		logic mem;
		logic [3:0] cond;
		logic [1:0] rsv1;
		logic [1:0] size;
		logic [1:0] rsv0;
		lsb_op_t op;
	} lsb_ctrl_t;
endpackage

// [src/lsb_unit.sv]
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module lsb_unit
	import lsb_pkg::*;
(
	input wire logic clk_i, // 200 MHz
	input wire logic rst_n_i, // sync reset
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB write
	input wire logic [11:0] paddr_i, // APB address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error
	input wire logic xrst_line_i, // reset line level
	output logic xrst_line_o, // reset line drive value
	output logic xrst_line_oe_o, // reset line driven low
	output logic exc_valid_o, // exception pulse
	output logic [1:0] exc_code_o, // exception kind
	output logic [3:0] exc_vec_o, // trap vector
	output logic done_o // op finished pulse
);
	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	function automatic logic [31:0] szm(input logic [1:0] s);
		return (s == SZ_B) ? 32'h000000FF : (s == SZ_W) ? 32'h0000FFFF : 32'hFFFFFFFF;
	endfunction
	function automatic logic msb(input logic [31:0] v, input logic [1:0] s);
		return (s == SZ_B) ? v[7] : (s == SZ_W) ? v[15] : v[31];
	endfunction
	function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [1:0] s);
		return (o & ~szm(s)) | (n & szm(s));
	endfunction
	function automatic logic [8:0] bcd(input logic [7:0] a, input logic [7:0] b, input logic x,
		input logic sub);
		logic [4:0] lo;
		logic [4:0] hi;
		if (sub) begin
			lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, x};
			if (lo[4]) lo = lo - 5'h06;
			hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo[4]};
			if (hi[4]) hi = hi - 5'h06;
		end else begin
			lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, x};
			if (lo > 5'h09) lo = lo + 5'h06;
			hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
			if (hi > 5'h09) hi = hi + 5'h06;
		end
		return {hi[4], hi[3:0], lo[3:0]};
	endfunction
	function automatic logic cok(input logic [3:0] c, input logic [15:0] f);
		logic n;
		logic z;
		logic v;
		logic k;
		n = f[SW_N];
		z = f[SW_Z];
		v = f[SW_V];
		k = f[SW_C];
		case (c)
			4'h0: cok = 1'b1;
			4'h1: cok = 1'b0;
			4'h2: cok = !k && !z;
			4'h3: cok = k || z;
			4'h4: cok = !k;
			4'h5: cok = k;
			4'h6: cok = !z;
			4'h7: cok = z;
			4'h8: cok = !v;
			4'h9: cok = v;
			4'hA: cok = !n;
			4'hB: cok = n;
			4'hC: cok = n == v;
			4'hD: cok = n != v;
			4'hE: cok = !z && (n == v);
			default: cok = z || (n != v);
		endcase
	endfunction
	// ---------------------------------------------
	// Registers
	// ---------------------------------------------
	lsb_ctrl_t ctrl_r;
	logic [31:0] opa_r, opb_r, imm_r, pc_r, disp_r, res_r, usp_r;
	logic [15:0] sw_r;
	logic [2:0] evt_r;
	logic go_r, stop_r, taken_r, sh_bsy_r;
	logic [31:0] sh_val_r;
	logic [5:0] sh_cnt_r;
	logic sh_c_r, sh_x_r, sh_v_r;
	logic [7:0] xr_cnt_r;
	logic xs1_r, xs2_r;
	logic [31:0] ex_res, ex_pc, ex_usp;
	logic [15:0] ex_sw;
	logic ex_we, ex_exc, ex_tk, ex_xr, ex_stop, ex_sh;
	logic [1:0] ex_code;
	// ---------------------------------------------
	// APB decode
	// ---------------------------------------------
	wire busy = go_r || sh_bsy_r;
	wire wr = psel_i && penable_i && pwrite_i;
	wire adr_ok = paddr_i <= OFS_INFO && paddr_i[1:0] == 2'h0;
	wire w_ctrl = wr && paddr_i == OFS_CTRL && !busy;
	wire w_evt = wr && paddr_i == OFS_EVT;
	wire [5:0] info = {xs2_r, xrst_line_oe_o, ctrl_r.mem, taken_r, stop_r, busy};
	wire [31:0] rd = (paddr_i == OFS_CTRL) ? ctrl_r :
		(paddr_i == OFS_OPA) ? opa_r : (paddr_i == OFS_OPB) ? opb_r :
		(paddr_i == OFS_IMM) ? imm_r : (paddr_i == OFS_SW) ? {16'h0000, sw_r} :
		(paddr_i == OFS_PC) ? pc_r : (paddr_i == OFS_DISP) ? disp_r :
		(paddr_i == OFS_RES) ? res_r : (paddr_i == OFS_EVT) ? {29'h0, evt_r} :
		(paddr_i == OFS_USP) ? usp_r : (paddr_i == OFS_INFO) ? {26'h0, info} : 32'h0;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !adr_ok;
	assign xrst_line_o = 1'b0;
	assign xrst_line_oe_o = xr_cnt_r != 8'h00;
	// ---------------------------------------------
	// Operand decode
	// ---------------------------------------------
	lsb_op_t op;
	assign op = ctrl_r.op;
	wire [1:0] sz = ctrl_r.size;
	wire sup = sw_r[SW_S];
	wire priv = op inside {OP_ERET, OP_XRST, OP_STOP, OP_USP, OP_ANDSW, OP_ORSW, OP_XORSW, OP_LDSW};
	wire pfail = priv && !sup;
	wire is_sh = op inside {[OP_ASHL:OP_RXR]};
	wire [31:0] lsrc = (op inside {[OP_ANDK:OP_XORI]}) ? imm_r : opb_r;
	wire [31:0] lraw = (op == OP_AND || op == OP_ANDK) ? (opa_r & lsrc) :
		(op == OP_OR || op == OP_ORK) ? (opa_r | lsrc) :
		(op == OP_NOT) ? ~opa_r : (opa_r ^ lsrc);
	wire [31:0] lres = lraw & szm(sz);
	wire [4:0] bn = (sz == SZ_B) ? {2'h0, opb_r[2:0]} : opb_r[4:0];
	wire [31:0] bmask = 32'h1 << bn;
	wire bsel = opa_r[bn];
	wire [8:0] dres = bcd((op == OP_DNEG) ? 8'h00 : opa_r[7:0],
		(op == OP_DNEG) ? opa_r[7:0] : opb_r[7:0], sw_r[SW_X], op != OP_DADD);
	wire cond = cok(ctrl_r.cond, sw_r);
	wire [31:0] dsp = ctrl_r.d16 ? {{16{disp_r[15]}}, disp_r[15:0]} : {{24{disp_r[7]}}, disp_r[7:0]};
	wire [15:0] dcnt = opa_r[15:0] - 16'h0001;
	wire signed [15:0] chk_v = opa_r[15:0];
	wire signed [15:0] chk_b = opb_r[15:0];
	wire [15:0] swi = imm_r[15:0];
	// Memory form is always a word moved by one place
	wire [1:0] shsz = ctrl_r.mem ? SZ_W : sz;
	wire [5:0] shcnt = ctrl_r.mem ? 6'h01 : ctrl_r.creg ? opb_r[5:0] :
		(ctrl_r.cnt == 3'h0) ? 6'h08 : {3'h0, ctrl_r.cnt};
	// ---------------------------------------------
	// One-bit shift step
	// ---------------------------------------------
	wire [31:0] shm = sh_val_r & szm(shsz);
	wire shmsb = msb(shm, shsz);
	wire left = op inside {OP_ASHL, OP_LSHL, OP_ROTL, OP_RXL};
	wire plain_rot = op inside {OP_ROTL, OP_ROTR};
	wire shin = (op == OP_ROTL || op == OP_ASHR) ? shmsb : (op == OP_ROTR) ? shm[0] :
		(op == OP_RXL || op == OP_RXR) ? sh_x_r : 1'b0;
	wire [31:0] top = (shsz == SZ_B) ? 32'h80 : (shsz == SZ_W) ? 32'h8000 : 32'h80000000;
	wire [31:0] shstep = left ? (((shm << 1) | {31'h0, shin}) & szm(shsz)) :
		((shm >> 1) | (shin ? top : 32'h0));
	wire shout = left ? shmsb : shm[0];
	wire sh_fin = sh_bsy_r && sh_cnt_r == 6'h00;
	// ---------------------------------------------
	// Single-cycle execution
	// ---------------------------------------------
	always_comb begin
		ex_res = res_r;
		ex_we = 1'b0;
		ex_sw = sw_r;
		ex_pc = pc_r;
		ex_usp = usp_r;
		ex_exc = 1'b0;
		ex_code = EXC_TRAP;
		ex_tk = 1'b0;
		ex_xr = 1'b0;
		ex_stop = 1'b0;
		ex_sh = 1'b0;
		if (pfail) begin
			ex_exc = 1'b1;
			ex_code = EXC_PRIV;
		end else begin
			case (op)
				OP_AND, OP_OR, OP_XOR, OP_NOT, OP_ANDK, OP_ORK, OP_XORI: begin
					ex_res = mrg(opa_r, lres, sz);
					ex_we = 1'b1;
					ex_sw[SW_N] = msb(lres, sz);
					ex_sw[SW_Z] = lres == 32'h0;
					ex_sw[SW_V] = 1'b0;
					ex_sw[SW_C] = 1'b0;
				end
				OP_ASHL, OP_ASHR, OP_LSHL, OP_LSHR, OP_ROTL, OP_ROTR, OP_RXL, OP_RXR: ex_sh = 1'b1;
				OP_BITT, OP_BITS, OP_BITC, OP_BINV: begin
					ex_sw[SW_Z] = !bsel;
					ex_we = op != OP_BITT;
					ex_res = (op == OP_BITS) ? (opa_r | bmask) :
						(op == OP_BITC) ? (opa_r & ~bmask) : (opa_r ^ bmask);
				end
				OP_DADD, OP_DSUB, OP_DNEG: begin
					ex_res = {opa_r[31:8], dres[7:0]};
					ex_we = 1'b1;
					ex_sw[SW_C] = dres[8];
					ex_sw[SW_X] = dres[8];
					if (dres[7:0] != 8'h00) ex_sw[SW_Z] = 1'b0;
				end
				OP_CBR: begin
					// Codes 0 and 1 are the always and subroutine forms
					ex_tk = ctrl_r.cond <= 4'h1 || cond;
					if (ex_tk) ex_pc = pc_r + dsp;
				end
				OP_DBR: if (!cond) begin
					ex_res = {opa_r[31:16], dcnt};
					ex_we = 1'b1;
					ex_tk = dcnt != 16'hFFFF;
					if (ex_tk) ex_pc = pc_r + {{16{disp_r[15]}}, disp_r[15:0]};
				end
				OP_CSET: begin
					ex_res = {opa_r[31:8], cond ? 8'hFF : 8'h00};
					ex_we = 1'b1;
				end
				OP_RTRF: begin
					ex_sw = (sw_r & ~CCB_MASK) | (opb_r[15:0] & CCB_MASK);
					ex_pc = opa_r;
				end
				OP_ERET: begin
					ex_sw = opb_r[15:0] & SW_IMPL;
					ex_pc = opa_r;
				end
				OP_XRST: ex_xr = 1'b1;
				OP_STOP: begin
					ex_sw = swi & SW_IMPL;
					ex_stop = 1'b1;
				end
				OP_USP: begin
					// mem selects the read-out direction
					if (ctrl_r.mem) begin
						ex_res = usp_r;
						ex_we = 1'b1;
					end else begin
						ex_usp = opa_r;
					end
				end
				OP_ANDSW: ex_sw = sw_r & swi;
				OP_ORSW: ex_sw = (sw_r | swi) & SW_IMPL;
				OP_XORSW: ex_sw = (sw_r ^ swi) & SW_IMPL;
				OP_LDSW: ex_sw = opb_r[15:0] & SW_IMPL;
				OP_ANDCC: ex_sw = sw_r & (swi | ~CCB_MASK);
				OP_ORCC: ex_sw = sw_r | (swi & CCB_MASK);
				OP_XORCC: ex_sw = sw_r ^ (swi & CCB_MASK);
				OP_LDCC: ex_sw = (sw_r & ~CCB_MASK) | (opb_r[15:0] & CCB_MASK);
				OP_STSW: begin
					ex_res = {opa_r[31:16], sw_r};
					ex_we = 1'b1;
				end
				OP_TRAP: ex_exc = 1'b1;
				OP_TRAPO: begin
					ex_exc = sw_r[SW_V];
					ex_code = EXC_TRAPO;
				end
				OP_CHK: begin
					ex_code = EXC_CHK;
					if (chk_v < 16'sh0000) begin
						ex_exc = 1'b1;
						ex_sw[SW_N] = 1'b1;
					end else if (chk_v > chk_b) begin
						ex_exc = 1'b1;
						ex_sw[SW_N] = 1'b0;
					end
				end
				default: ex_exc = 1'b0;
			endcase
		end
	end
	wire [31:0] sh_res = mrg(opa_r, shm, shsz);
	wire xg = go_r && !pfail;
	wire [2:0] ev_set = {go_r && ex_exc && pfail, go_r && ex_exc && !pfail, (go_r && !ex_sh) || sh_fin};
	// ---------------------------------------------
	// Sequential state
	// ---------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_r <= '0;
			go_r <= 1'b0;
			{opa_r, opb_r, imm_r, pc_r, disp_r, usp_r} <= '0;
			prdata_o <= 32'h0;
		end else begin
			go_r <= w_ctrl;
			if (w_ctrl) ctrl_r <= lsb_ctrl_t'(pwdata_i);
			if (psel_i && !penable_i) prdata_o <= rd;
			if (wr && paddr_i == OFS_OPA) opa_r <= pwdata_i;
			if (wr && paddr_i == OFS_OPB) opb_r <= pwdata_i;
			if (wr && paddr_i == OFS_IMM) imm_r <= pwdata_i;
			if (wr && paddr_i == OFS_DISP) disp_r <= pwdata_i;
			if (xg) pc_r <= ex_pc;
			else if (wr && paddr_i == OFS_PC) pc_r <= pwdata_i;
			if (xg) usp_r <= ex_usp;
			else if (wr && paddr_i == OFS_USP) usp_r <= pwdata_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sw_r <= SW_RST;
			res_r <= 32'h0;
			evt_r <= 3'h0;
			{stop_r, taken_r, exc_valid_o, done_o} <= '0;
			exc_code_o <= EXC_TRAP;
			exc_vec_o <= 4'h0;
		end else begin
			// Hardware set beats a simultaneous write-one clear
			evt_r <= (evt_r & ~(w_evt ? pwdata_i[2:0] : 3'h0)) | ev_set;
			exc_valid_o <= go_r && ex_exc;
			done_o <= ev_set[EV_DONE];
			if (go_r) exc_code_o <= ex_code;
			if (go_r) exc_vec_o <= ctrl_r.vec;
			if (xg) taken_r <= ex_tk;
			if (w_ctrl) stop_r <= 1'b0;
			else if (xg && ex_stop) stop_r <= 1'b1;
			if (sh_fin) begin
				res_r <= sh_res;
				sw_r[SW_N] <= msb(shm, shsz);
				sw_r[SW_Z] <= shm == 32'h0;
				sw_r[SW_V] <= sh_v_r;
				sw_r[SW_C] <= sh_c_r;
				if (!plain_rot) sw_r[SW_X] <= sh_x_r;
			end else if (xg) begin
				sw_r <= ex_sw;
				if (ex_we) res_r <= ex_res;
			end else if (wr && paddr_i == OFS_SW) begin
				sw_r <= pwdata_i[15:0] & SW_IMPL;
			end
		end
	end
	// ---------------------------------------------
	// Iterative shifter and reset line
	// ---------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sh_bsy_r <= 1'b0;
			sh_val_r <= 32'h0;
			sh_cnt_r <= 6'h00;
			{sh_c_r, sh_x_r, sh_v_r} <= '0;
			xr_cnt_r <= 8'h00;
		end else begin
			if (xg && ex_sh) begin
				sh_bsy_r <= 1'b1;
				sh_val_r <= opa_r;
				sh_cnt_r <= shcnt;
				sh_c_r <= (op == OP_RXL || op == OP_RXR) && sw_r[SW_X];
				sh_x_r <= sw_r[SW_X];
				sh_v_r <= 1'b0;
			end else if (sh_fin) begin
				sh_bsy_r <= 1'b0;
			end else if (sh_bsy_r) begin
				sh_val_r <= shstep;
				sh_cnt_r <= sh_cnt_r - 6'h01;
				sh_c_r <= shout;
				sh_x_r <= shout;
				if (op == OP_ASHL && msb(shstep, shsz) != shmsb) sh_v_r <= 1'b1;
			end
			// Line pulse length is fixed; no core state is touched
			if (xg && ex_xr) xr_cnt_r <= 8'(XRST_CYC);
			else if (xr_cnt_r != 8'h00) xr_cnt_r <= xr_cnt_r - 8'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			{xs1_r, xs2_r} <= 2'b11;
		end else begin
			xs1_r <= xrst_line_i;
			xs2_r <= xs1_r;
		end
	end
	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] oe_len_r;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) oe_len_r <= 8'h00;
		else oe_len_r <= xrst_line_oe_o ? oe_len_r + 8'h01 : 8'h00;
	end
	a_logic_flags: assert property (go_r && !pfail && op inside {[OP_AND:OP_XORI]} |=>
		!sw_r[SW_V] && !sw_r[SW_C] && sw_r[SW_X] == $past(sw_r[SW_X]))
		else $error("logic op flags wrong");
	a_bit_test_zero: assert property (go_r && op == OP_BITT |=> sw_r[SW_Z] == !$past(bsel))
		else $error("bit test zero flag wrong");
	a_bit_set_res: assert property (go_r && op == OP_BITS |=> res_r == $past(opa_r | bmask))
		else $error("bit set result wrong");
	a_priv_block: assert property (go_r && pfail |=> exc_valid_o && exc_code_o == EXC_PRIV
		&& sw_r == $past(sw_r) && !xrst_line_oe_o) else $error("privileged op not blocked");
	a_mem_shift: assert property (go_r && is_sh && ctrl_r.mem |=> sh_bsy_r[*2] ##1 !sh_bsy_r)
		else $error("memory shift not one bit");
	a_ovf_trap: assert property (go_r && op == OP_TRAPO |=> exc_valid_o == $past(sw_r[SW_V]))
		else $error("overflow trap wrong");
	a_xrst_len: assert property ($fell(xrst_line_oe_o) |-> oe_len_r == 8'(XRST_CYC))
		else $error("reset line pulse length wrong");
	a_cset_byte: assert property (go_r && op == OP_CSET |=> res_r[7:0] == ($past(cond) ? 8'hFF : 8'h00))
		else $error("conditional set byte wrong");
	a_branch_pc: assert property (go_r && op == OP_CBR && cond |=> pc_r == $past(pc_r + dsp))
		else $error("branch target wrong");
	c_reg_shift: cover property (go_r && is_sh && ctrl_r.creg && opb_r[5:0] > 6'h08);
	c_trap: cover property (exc_valid_o && exc_code_o == EXC_CHK);
	c_dadd: cover property (go_r && op == OP_DADD && dres[8]);
	c_dbr_wrap: cover property (go_r && op == OP_DBR && !cond && dcnt == 16'hFFFF);
endmodule

// [testbench/lsb_bench.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cpu_logic_shift_bit_bcd_ctrl_unit_bench;
	import lsb_pkg::*;
	// ----------------
	// Signals
	// ----------------
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o, rd, res_q;
	logic pready_o, pslverr_o, xrst_line_o, xrst_line_oe_o, exc_valid_o, done_o, err;
	logic [1:0] exc_code_o, code_q;
	logic [3:0] exc_vec_o, vec_q;
	logic [15:0] sw_q;
	wire xrst_line_i;
	int bad_count = 0, tests_run = 0, exc_n = 0, oe_n = 0, done_n = 0, n0, o0, d0;
	always #2.5 clk_i = ~clk_i;
	// Pulled up; low only while the block drives it
	assign xrst_line_i = (xrst_line_oe_o === 1'b1) ? xrst_line_o : 1'b1;
	always @(posedge clk_i) begin
		if (exc_valid_o === 1'b1) begin
			exc_n <= exc_n + 1;
			code_q <= exc_code_o;
			vec_q <= exc_vec_o;
		end
		if (xrst_line_oe_o === 1'b1) oe_n <= oe_n + 1;
		if (done_o === 1'b1) done_n <= done_n + 1;
	end
	lsb_unit u_lsb_unit (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .xrst_line_i(xrst_line_i), .xrst_line_o(xrst_line_o),
		.xrst_line_oe_o(xrst_line_oe_o), .exc_valid_o(exc_valid_o), .exc_code_o(exc_code_o),
		.exc_vec_o(exc_vec_o), .done_o(done_o));
	// ----------------
	// Bus and op helpers
	// ----------------
	task final_report;
		if (bad_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task hang;
		bad_count++;
		final_report();
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 50) hang();
	endtask
	task go(input lsb_op_t o, input logic [1:0] sz, input logic [15:0] sw, input logic [31:0] a,
		input logic [31:0] b, input logic [3:0] cnd = 4'h0, input logic [2:0] cnt = 3'h1, input logic cr = 1'b0,
		input logic mem = 1'b0, input logic [3:0] vec = 4'h0);
		lsb_ctrl_t c;
		int n;
		c = '{rsv3: 4'h0, vec: vec, rsv2: 2'h0, d16: 1'b0, cnt: cnt, creg: cr, mem: mem, cond: cnd,
			rsv1: 2'h0, size: sz, rsv0: 2'h0, op: o};
		apb(1'b1, OFS_SW, {16'h0, sw});
		apb(1'b1, OFS_OPA, a);
		apb(1'b1, OFS_OPB, b);
		d0 = done_n;
		apb(1'b1, OFS_CTRL, c);
		// Busy shows only after the go edge, so polling starts late
		repeat (2) @(posedge clk_i);
		n = 0;
		do begin
			apb(1'b0, OFS_INFO, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 60);
		if (n >= 60) hang();
		`CHK(done_n - d0, 1)
		apb(1'b0, OFS_RES, 32'h0);
		res_q = rd;
		apb(1'b0, OFS_SW, 32'h0);
		sw_q = rd[15:0];
	endtask
	task row(input lsb_op_t o, input logic [1:0] sz, input logic [15:0] sw, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] res, input logic [15:0] swx, input logic [2:0] cnt = 3'h1,
		input logic cr = 1'b0, input logic mem = 1'b0);
		go(o, sz, sw, a, b, 4'h0, cnt, cr, mem);
		`CHK(res_q, res)
		if (swx != 16'h0) `CHK(sw_q, swx)
	endtask
	task trp(input lsb_op_t o, input logic [15:0] sw, input logic [31:0] a, input logic [31:0] b,
		input logic [3:0] vec, input int want, input logic [1:0] code);
		n0 = exc_n;
		go(o, SZ_W, sw, a, b, 4'h0, 3'h1, 1'b0, 1'b0, vec);
		`CHK(exc_n - n0, want)
		if (want == 1) `CHK({code_q, vec_q}, {code, vec})
	endtask
	task br(input lsb_op_t o, input logic [3:0] cnd, input logic [31:0] a, input logic [31:0] pc);
		apb(1'b1, OFS_PC, 32'h1000);
		go(o, SZ_W, 16'h2700, a, 32'h1F, cnd);
		apb(1'b0, OFS_PC, 32'h0);
		`CHK(rd, pc)
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task t_reset;
		apb(1'b0, OFS_SW, 32'h0);
		`CHK(rd[15:0], SW_RST)
		apb(1'b0, 12'h030, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b0, OFS_INFO, 32'h0);
		`CHK(err, 1'b0)
	endtask
	task t_logic;
		logic [7:0] e [7];
		e = '{8'h24, 8'hBD, 8'h99, 8'h5A, 8'h24, 8'hBD, 8'h99};
		apb(1'b1, OFS_IMM, 32'h0F0F003C);
		// Immediate forms get a zero source so a wrong operand pick shows
		for (int i = 0; i < 7; i++) begin
			row(lsb_op_t'(6'(i)), SZ_B, 16'h2713, 32'h123456A5, (i < 4) ? 32'h3C : 32'h0,
				{24'h123456, e[i]}, {12'h271, e[i][7], e[i] == 8'h0, 2'b00});
		end
		row(OP_XORI, 2'h2, 16'h2703, 32'hF0F0003C, 32'h0, 32'hFFFF0000, 16'h2708);
		row(OP_OR, SZ_W, 16'h2700, 32'hAAAA0000, 32'h55550000, 32'hAAAA0000, 16'h2704);
	endtask
	task t_shift;
		row(OP_LSHL, SZ_B, 16'h2700, 32'h111111FF, 32'h0, 32'h11111100, 16'h0, 3'h0);
		row(OP_ASHR, SZ_B, 16'h2700, 32'h80, 32'h0, 32'hF0, 16'h0, 3'h3);
		row(OP_ASHL, SZ_W, 16'h2700, 32'h4001, 32'h0, 32'h8002, 16'h0);
		row(OP_LSHR, 2'h2, 16'h2700, 32'h80000000, 32'h4, 32'h08000000, 16'h0, 3'h1, 1'b1);
		row(OP_LSHR, 2'h2, 16'h2700, 32'hFFFFFFFF, 32'h3F, 32'h0, 16'h0, 3'h1, 1'b1);
		row(OP_ROTR, 2'h2, 16'h2700, 32'h12345678, 32'h0, 32'h12345678, 16'h0, 3'h1, 1'b1);
		row(OP_ROTL, SZ_W, 16'h2700, 32'h1234, 32'h0, 32'h2341, 16'h0, 3'h4);
		row(OP_ROTR, SZ_B, 16'h2700, 32'h01, 32'h0, 32'h80, 16'h0);
		row(OP_RXL, SZ_B, 16'h2710, 32'h80, 32'h0, 32'h01, 16'h0);
		row(OP_RXR, SZ_B, 16'h2710, 32'h0, 32'h0, 32'h80, 16'h0);
		// Count field says five; memory form must still move one place
		row(OP_LSHL, SZ_W, 16'h2700, 32'h3, 32'h0, 32'h6, 16'h0, 3'h5, 1'b0, 1'b1);
	endtask
	task t_bits_bcd;
		row(OP_BITS, SZ_B, 16'h2700, 32'h0, 32'h9, 32'h02, 16'h2704);
		row(OP_BITC, 2'h2, 16'h2704, 32'h80000000, 32'h1F, 32'h0, 16'h2700);
		row(OP_BINV, SZ_B, 16'h2704, 32'h10, 32'h4, 32'h0, 16'h2700);
		go(OP_BITT, 2'h2, 16'h2700, 32'h0, 32'h1E);
		`CHK(sw_q, 16'h2704)
		row(OP_DADD, SZ_B, 16'h2710, 32'h45, 32'h38, 32'h84, 16'h0);
		row(OP_DSUB, SZ_B, 16'h2710, 32'h10, 32'h01, 32'h08, 16'h0);
		row(OP_DNEG, SZ_B, 16'h2710, 32'h01, 32'h0, 32'h98, 16'h0);
	endtask
	task t_cond;
		logic [15:0] sws [2];
		logic [15:0] ex [2];
		sws = '{16'h2709, 16'h2706};
		ex = '{16'hA969, 16'hA699};
		for (int k = 0; k < 2; k++) begin
			for (int c = 0; c < 16; c++) begin
				go(OP_CSET, SZ_B, sws[k], 32'h5A5A5A5A, 32'h0, 4'(c));
				`CHK(res_q, {24'h5A5A5A, {8{ex[k][c]}}})
			end
		end
		apb(1'b1, OFS_DISP, 32'h20);
		br(OP_CBR, 4'h6, 32'h0, 32'h1020);
		br(OP_CBR, 4'h7, 32'h0, 32'h1000);
		br(OP_DBR, 4'h1, 32'h5, 32'h1020);
		br(OP_DBR, 4'h1, 32'h0, 32'h1000);
		br(OP_DBR, 4'h0, 32'h5, 32'h1000);
		br(OP_RTRF, 4'h0, 32'h2000, 32'h2000);
		`CHK(sw_q, 16'h271F)
	endtask
	task t_system;
		lsb_op_t pv [8];
		pv = '{OP_ERET, OP_XRST, OP_STOP, OP_USP, OP_ANDSW, OP_ORSW, OP_XORSW, OP_LDSW};
		apb(1'b1, OFS_IMM, 32'h2000);
		o0 = oe_n;
		foreach (pv[i]) begin
			trp(pv[i], 16'h0700, 32'h0, 32'h2700, 4'h0, 1, EXC_PRIV);
			`CHK(sw_q, 16'h0700)
		end
		apb(1'b0, OFS_EVT, 32'h0);
		`CHK(rd[EV_PRIV], 1'b1)
		trp(OP_XRST, 16'h2704, 32'h0, 32'h0, 4'h0, 0, EXC_PRIV);
		repeat (XRST_CYC + 4) @(posedge clk_i);
		`CHK(oe_n - o0, XRST_CYC)
		`CHK(sw_q, 16'h2704)
	endtask
	task t_flags_traps;
		apb(1'b1, OFS_IMM, 32'h11);
		trp(OP_ORCC, 16'h0704, 32'h0, 32'h0, 4'h0, 0, EXC_TRAP);
		`CHK(sw_q, 16'h0715)
		trp(OP_ANDCC, 16'h071F, 32'h0, 32'h0, 4'h0, 0, EXC_TRAP);
		`CHK(sw_q, 16'h0711)
		trp(OP_XORCC, 16'h0701, 32'h0, 32'h0, 4'h0, 0, EXC_TRAP);
		`CHK(sw_q, 16'h0710)
		trp(OP_LDCC, 16'h0700, 32'h0, 32'h1A, 4'h0, 0, EXC_TRAP);
		`CHK(sw_q, 16'h071A)
		trp(OP_STSW, 16'h0715, 32'hABCD0000, 32'h0, 4'h0, 0, EXC_TRAP);
		`CHK(res_q, 32'hABCD0715)
		trp(OP_TRAP, 16'h2700, 32'h0, 32'h0, 4'h9, 1, EXC_TRAP);
		trp(OP_TRAPO, 16'h2700, 32'h0, 32'h0, 4'h0, 0, EXC_TRAPO);
		trp(OP_TRAPO, 16'h2702, 32'h0, 32'h0, 4'h3, 1, EXC_TRAPO);
		trp(OP_CHK, 16'h2700, 32'h10, 32'h8, 4'h0, 1, EXC_CHK);
		trp(OP_CHK, 16'h2700, 32'hFFFF, 32'h8, 4'h0, 1, EXC_CHK);
		trp(OP_CHK, 16'h2700, 32'h8, 32'h8, 4'h0, 0, EXC_CHK);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_logic();
		t_shift();
		t_bits_bcd();
		t_cond();
		t_system();
		t_flags_traps();
		final_report();
	end
endmodule
